// file: hdl/asr_regs.sv
// analog supervision register bank with axi4-lite slave
//
// Function
// [R1] rw power control register at 0x01 holds enables and trim
// [R2] bit 6 enables the 20 v regulator
// [R3] bit 5 enables the second dc-dc converter
// [R4] bit 4 enables the clock output pin
// [R5] bit 3 drives tx activity onto trigger pin, else tri-state
// [R6] bits 2..0 are a 3-bit current limit trim code
// [R7] bit 7 of power control is reserved
// [R8] rw monitor config register at 0x02
// [R9] bits 6..4 mask supply monitors from the save warning
// [R10] analog output select 000 disables monitor output
// [R11] select codes 001..111 route fixed analog sources
// [R12] bits 0 and 7 of monitor config are reserved
// [R13] read-only status register at 0x03, bit 7 reserved
// [R14] supply bits read 1 while above undervoltage threshold
// [R15] crystal bit reads 1 while oscillator runs
// [R16] thermal warning bit reads 1 while warning present
// [R17] thermal shutdown bit reads 1 once a shutdown occurred
// [R18] reserved bits read zero, writes to them ignored
// [R19] status writes ignored, inputs synchronised before read
module asr_regs (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               clk_en,
  input  wire logic [5:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [5:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               hv_rail_ok,
  input  wire logic               second_rail_ok,
  input  wire logic               bus_voltage_ok,
  input  wire logic               filter_voltage_ok,
  input  wire logic               xtal_running,
  input  wire logic               thermal_warning,
  input  wire logic               thermal_shutdown_seen,
  input  wire logic               tx_activity,
  output logic                    hv_regulator_enable,
  output logic                    second_converter_enable,
  output logic                    clock_out_enable,
  output logic                    trigger_pin_o,
  output logic                    trigger_pin_oe,
  output logic [2:0]              hv_current_limit_trim,
  output logic [2:0]              analog_output_select,
  output logic                    analog_output_enable,
  output logic                    save_warning_n,
  output logic                    irq
);
  default clocking asr_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0]  pwr_ctrl_r;
  logic [7:0]  mon_cfg_r;
  logic [6:0]  sync1_r;
  logic [6:0]  sync2_r;
  logic [7:0]  status_r;
  logic [7:0]  irq_stat_r;
  logic [7:0]  irq_mask_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic [3:0]  aw_idx_r;
  logic [7:0]  wdata_r;
  logic        wstrb0_r;
  logic [7:0]  status_prev_r;

  logic [6:0]  raw_in;
  logic        do_write;
  logic [3:0]  ar_idx;
  logic [7:0]  ev_fall;
  logic        wr_ok;

  assign raw_in = {hv_rail_ok, second_rail_ok, bus_voltage_ok,
                   filter_voltage_ok, xtal_running, thermal_warning,
                   thermal_shutdown_seen};
  assign do_write = aw_got_r && w_got_r && !s_axi_bvalid;
  assign ar_idx   = s_axi_araddr[5:2];
  assign wr_ok    = (aw_idx_r == asr_pkg::IDX_PWR_CTRL) ||
                    (aw_idx_r == asr_pkg::IDX_MON_CFG) ||
                    (aw_idx_r == asr_pkg::IDX_STATUS) ||
                    (aw_idx_r == asr_pkg::IDX_IRQ_STAT) ||
                    (aw_idx_r == asr_pkg::IDX_IRQ_MASK);

  // ------------------------------------------------------------
  // status input synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r  <= 7'h00;
      sync2_r  <= 7'h00;
      status_r <= asr_pkg::RST_STATUS;
    end else if (clk_en) begin
      sync1_r  <= raw_in; // [R19]
      sync2_r  <= sync1_r;
      // bit 7 reserved, forced zero; flags [R14] [R15] [R16] [R17]
      status_r <= {1'b0, sync2_r} & asr_pkg::WMASK_STATUS; // [R13]
    end
  end

  // ------------------------------------------------------------
  // write channel
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_idx_r      <= 4'h0;
      wdata_r       <= 8'h00;
      wstrb0_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= asr_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_got_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr[5:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r  <= 1'b1;
        wdata_r  <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? asr_pkg::RESP_OKAY : asr_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_ctrl_r <= asr_pkg::RST_PWR_CTRL;
      mon_cfg_r  <= asr_pkg::RST_MON_CFG;
      irq_mask_r <= asr_pkg::RST_IRQ_MASK;
    end else if (clk_en && do_write && wstrb0_r) begin
      // status index is accepted but changes nothing
      if (aw_idx_r == asr_pkg::IDX_PWR_CTRL)
        pwr_ctrl_r <= wdata_r & asr_pkg::WMASK_PWR_CTRL; // [R1] [R7] [R18]
      if (aw_idx_r == asr_pkg::IDX_MON_CFG)
        mon_cfg_r <= wdata_r & asr_pkg::WMASK_MON_CFG; // [R8] [R12] [R18]
      if (aw_idx_r == asr_pkg::IDX_IRQ_MASK)
        irq_mask_r <= wdata_r & asr_pkg::WMASK_STATUS;
    end
  end

  // ------------------------------------------------------------
  // interrupts: any status bit falling is an event
  // ------------------------------------------------------------
  assign ev_fall = status_prev_r & ~status_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_prev_r <= asr_pkg::RST_STATUS;
      irq_stat_r    <= 8'h00;
      irq           <= 1'b0;
    end else if (clk_en) begin
      status_prev_r <= status_r;
      // set wins over write-one-to-clear
      irq_stat_r <= (irq_stat_r & ~((do_write && wstrb0_r &&
                    aw_idx_r == asr_pkg::IDX_IRQ_STAT) ? wdata_r : 8'h00))
                    | ev_fall;
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= asr_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= asr_pkg::RESP_OKAY;
        case (ar_idx)
          asr_pkg::IDX_PWR_CTRL: s_axi_rdata <= {24'h0, pwr_ctrl_r};
          asr_pkg::IDX_MON_CFG:  s_axi_rdata <= {24'h0, mon_cfg_r};
          asr_pkg::IDX_STATUS:   s_axi_rdata <= {24'h0, status_r};
          asr_pkg::IDX_IRQ_STAT: s_axi_rdata <= {24'h0, irq_stat_r};
          asr_pkg::IDX_IRQ_MASK: s_axi_rdata <= {24'h0, irq_mask_r};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= asr_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // analog control outputs, registered
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hv_regulator_enable     <= 1'b0;
      second_converter_enable <= 1'b0;
      clock_out_enable        <= 1'b0;
      trigger_pin_o           <= 1'b0;
      trigger_pin_oe          <= 1'b0;
      hv_current_limit_trim   <= 3'h0;
      analog_output_select    <= 3'h0;
      analog_output_enable    <= 1'b0;
      save_warning_n          <= 1'b1;
    end else if (clk_en) begin
      hv_regulator_enable     <= pwr_ctrl_r[asr_pkg::BIT_HV_EN]; // [R2]
      second_converter_enable <= pwr_ctrl_r[asr_pkg::BIT_CONV2_EN]; // [R3]
      clock_out_enable        <= pwr_ctrl_r[asr_pkg::BIT_CLKOUT_EN]; // [R4]
      // pin released, not driven low, when disabled
      trigger_pin_oe <= pwr_ctrl_r[asr_pkg::BIT_TRIG_EN]; // [R5]
      trigger_pin_o  <= pwr_ctrl_r[asr_pkg::BIT_TRIG_EN] & tx_activity; // [R5]
      hv_current_limit_trim <=
        pwr_ctrl_r[asr_pkg::TRIM_LSB +: asr_pkg::TRIM_W]; // [R6]
      // source mux itself is analog; code passed through
      analog_output_select <=
        mon_cfg_r[asr_pkg::SEL_LSB +: asr_pkg::SEL_W]; // [R11]
      analog_output_enable <= // [R10]
        mon_cfg_r[asr_pkg::SEL_LSB +: asr_pkg::SEL_W] != asr_pkg::SEL_OFF;
      // unmasked monitor low asserts the warning
      save_warning_n <= !(
        (!mon_cfg_r[asr_pkg::BIT_HV_MASK]    && !sync2_r[6]) ||
        (!mon_cfg_r[asr_pkg::BIT_CONV2_MASK] && !sync2_r[5]) ||
        (!mon_cfg_r[asr_pkg::BIT_FILT_MASK]  && !sync2_r[3])); // [R9]
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  // sampled reset in every |=> antecedent: reset leaves at a clock edge,
  // so the first live cycle must not look back into reset
  sequence s_live;
    aresetn && clk_en;
  endsequence

  sequence s_ctrl_wr;
    s_live ##0 do_write && wstrb0_r && aw_idx_r == asr_pkg::IDX_PWR_CTRL;
  endsequence

  sequence s_cfg_wr;
    s_live ##0 do_write && wstrb0_r && aw_idx_r == asr_pkg::IDX_MON_CFG;
  endsequence

  sequence s_stat_wr;
    s_live ##0 do_write && aw_idx_r == asr_pkg::IDX_STATUS;
  endsequence

  sequence s_sync_run;
    s_live ##1 clk_en ##1 clk_en;
  endsequence

  a_ctrl_write_store: assert property ( // [R1]
    s_ctrl_wr |=> pwr_ctrl_r == ($past(wdata_r) & 8'h7f))
    else $error("power control write not stored");
  a_hv_enable_follow: assert property ( // [R2]
    s_live |=> hv_regulator_enable == $past(pwr_ctrl_r[6]))
    else $error("hv enable mismatch");
  a_conv_enable_follow: assert property ( // [R3]
    s_live |=> second_converter_enable == $past(pwr_ctrl_r[5]))
    else $error("converter enable mismatch");
  a_clkout_follow: assert property ( // [R4]
    s_live |=> clock_out_enable == $past(pwr_ctrl_r[4]))
    else $error("clock out enable mismatch");
  a_trig_tristate: assert property ( // [R5]
    !trigger_pin_oe |-> !trigger_pin_o)
    else $error("trigger driven while tri-stated");
  a_trig_follow: assert property ( // [R5]
    s_live |=> trigger_pin_oe == $past(pwr_ctrl_r[3]))
    else $error("trigger enable mismatch");
  a_trim_follow: assert property ( // [R6]
    s_live |=> hv_current_limit_trim == $past(pwr_ctrl_r[2:0]))
    else $error("current limit trim mismatch");
  a_ctrl_reserved_zero: assert property ( // [R7] [R12] [R18]
    !pwr_ctrl_r[7] && !mon_cfg_r[7] && !mon_cfg_r[0])
    else $error("reserved bit set");
  a_cfg_write_store: assert property ( // [R8]
    s_cfg_wr |=> mon_cfg_r == ($past(wdata_r) & 8'h7e))
    else $error("monitor config write not stored");
  a_anaout_off: assert property ( // [R10]
    s_live ##0 mon_cfg_r[3:1] == 3'h0 |=> !analog_output_enable)
    else $error("analog output not disabled");
  a_anaout_route: assert property ( // [R11]
    s_live ##0 mon_cfg_r[3:1] != 3'h0 |=>
      analog_output_enable && analog_output_select == $past(mon_cfg_r[3:1]))
    else $error("analog output select mismatch");
  a_save_warn_masked: assert property ( // [R9]
    s_live ##0 mon_cfg_r[6:4] == 3'h7 |=> save_warning_n)
    else $error("masked monitors still warn");
  a_save_warn_fire: assert property ( // [R9]
    s_live ##0 !mon_cfg_r[6] && !sync2_r[6] |=> !save_warning_n)
    else $error("unmasked hv monitor did not warn");
  a_save_warn_filter: assert property ( // [R9]
    s_live ##0 !mon_cfg_r[4] && !sync2_r[3] |=> !save_warning_n)
    else $error("unmasked filter monitor did not warn");
  a_status_sync_path: assert property ( // [R19]
    s_sync_run |=> status_r[6:0] == $past(raw_in, 3))
    else $error("status not three-stage synchronised");
  a_status_top_zero: assert property ( // [R13]
    !status_r[7])
    else $error("status reserved bit set");
  a_status_write_ignored: assert property ( // [R19]
    s_stat_wr |=>
      $stable(pwr_ctrl_r) && $stable(mon_cfg_r) && $stable(irq_mask_r))
    else $error("status write changed a register");
  a_status_freeze: assert property ( // [R19]
    aresetn && !clk_en |=> $stable(status_r) && $stable(sync2_r))
    else $error("status moved while clock enable low");
  a_ctrl_hold: assert property ( // [R1]
    aresetn && !do_write |=> $stable(pwr_ctrl_r))
    else $error("power control changed without a write");
  a_cfg_hold: assert property ( // [R8]
    aresetn && !do_write |=> $stable(mon_cfg_r))
    else $error("monitor config changed without a write");
endmodule // asr_regs

// file: hdl/asr_pkg.sv
// constants for the analog supervision register bank
package asr_pkg;
  // ------------------------------------------------------------
  // register indices and address width
  // ------------------------------------------------------------
  localparam logic [3:0] IDX_PWR_CTRL = 4'h1;
  localparam logic [3:0] IDX_MON_CFG  = 4'h2;
  localparam logic [3:0] IDX_STATUS   = 4'h3;
  localparam logic [3:0] IDX_IRQ_STAT = 4'h8;
  localparam logic [3:0] IDX_IRQ_MASK = 4'h9;
  localparam int ADDR_W = 6;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_PWR_CTRL = 8'h74;
  localparam logic [7:0] RST_MON_CFG  = 8'h60;
  localparam logic [7:0] RST_STATUS   = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  // ------------------------------------------------------------
  // writable bit masks, reserved bits stay zero
  // ------------------------------------------------------------
  localparam logic [7:0] WMASK_PWR_CTRL = 8'h7f;
  localparam logic [7:0] WMASK_MON_CFG  = 8'h7e;
  localparam logic [7:0] WMASK_STATUS   = 8'h7f;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_HV_EN      = 6;
  localparam int BIT_CONV2_EN   = 5;
  localparam int BIT_CLKOUT_EN  = 4;
  localparam int BIT_TRIG_EN    = 3;
  localparam int TRIM_LSB       = 0;
  localparam int TRIM_W         = 3;
  localparam int BIT_HV_MASK    = 6;
  localparam int BIT_CONV2_MASK = 5;
  localparam int BIT_FILT_MASK  = 4;
  localparam int SEL_LSB        = 1;
  localparam int SEL_W          = 3;
  localparam logic [2:0] SEL_OFF = 3'h0;
  // ------------------------------------------------------------
  // axi responses
  // ------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: sim/asr_host.sv
// host controller model: axi4-lite master for register traffic
module asr_host (
  input  wire logic        aclk,
  output logic [5:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  output logic             bready,
  input  wire logic        bvalid,
  output logic [5:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  output logic             rready,
  input  wire logic        rvalid,
  output logic             hang
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, hang} = '0;
  end
  // ------------------------------------------------------------
  // bus cycles, no fixed latency assumed
  // ------------------------------------------------------------
  task automatic wr(input logic [5:0] a, input logic [7:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // bready held from the start so the answer is taken at once
    while (!(bready && bvalid) && n < 64) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (n >= 64) hang <= 1'b1;
  endtask
  task automatic rd(input logic [5:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!(rready && rvalid) && n < 64) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (n >= 64) hang <= 1'b1;
  endtask
endmodule // asr_host

// file: sim/analog_supervision_regs_tb.sv
// self-checking bench for the analog supervision register bank
module analog_supervision_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] A_CTRL = {asr_pkg::IDX_PWR_CTRL, 2'b00};
  localparam logic [5:0] A_CFG  = {asr_pkg::IDX_MON_CFG, 2'b00};
  localparam logic [5:0] A_STAT = {asr_pkg::IDX_STATUS, 2'b00};
  localparam logic [5:0] A_IST  = {asr_pkg::IDX_IRQ_STAT, 2'b00};
  localparam logic [5:0] A_IMSK = {asr_pkg::IDX_IRQ_MASK, 2'b00};
  localparam logic [1:0] OK = asr_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = asr_pkg::RESP_SLVERR;
  logic        aclk, aresetn, clk_en, tx_act, hang;
  logic [6:0]  stat;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        hv_en, conv_en, clk_oe, trig_o, trig_oe, ana_en;
  logic        save_n, irq;
  logic [2:0]  trim, sel;
  int          error_cnt, checks_done, cyc;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];

  asr_regs dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .hv_rail_ok(stat[6]),
    .second_rail_ok(stat[5]), .bus_voltage_ok(stat[4]),
    .filter_voltage_ok(stat[3]), .xtal_running(stat[2]),
    .thermal_warning(stat[1]), .thermal_shutdown_seen(stat[0]),
    .tx_activity(tx_act), .hv_regulator_enable(hv_en),
    .second_converter_enable(conv_en), .clock_out_enable(clk_oe),
    .trigger_pin_o(trig_o), .trigger_pin_oe(trig_oe),
    .hv_current_limit_trim(trim), .analog_output_select(sel),
    .analog_output_enable(ana_en), .save_warning_n(save_n), .irq(irq));

  asr_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bready(bready), .bvalid(bvalid), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rready(rready), .rvalid(rvalid),
    .hang(hang));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(string name, logic [33:0] seen, logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      error_cnt++;
    end
  endtask
  task automatic end_sim();
    if (bq.size() != 0 || rq.size() != 0) error_cnt++;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(logic [5:0] a, logic [7:0] d, logic [1:0] r,
                    logic [3:0] s = 4'h1);
    bq.push_back(r);
    host.wr(a, d, s);
  endtask
  task automatic rd(logic [5:0] a, logic [7:0] d, logic [1:0] r = OK);
    rq.push_back({r, 24'h0, d});
    host.rd(a);
  endtask
  task automatic settle(int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  // ------------------------------------------------------------
  // clock, watchdog and response monitor
  // ------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (bvalid && bready && bq.size() > 0)
      check("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
    if (rvalid && rready && rq.size() > 0)
      check("rdata", {rresp, rdata}, rq.pop_front());
    if (hang || cyc > 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] v;
    logic [6:0] s;
    logic       t;
    int         sb[3];
    int         mb[3];
    sb = '{6, 5, 3};
    mb = '{6, 5, 4};
    v = $urandom(43);
    {aresetn, tx_act, stat} = '0;
    clk_en = 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    settle(2);
    check("ctrl_outs", {hv_en, conv_en, clk_oe, trig_oe, trim}, 7'h74);
    rd(A_CTRL, 8'h74);
    rd(A_CFG, 8'h60);
    rd(A_STAT, 8'h00);
    rd(A_IMSK, 8'h00);
    $display("reset test done");
    // all-ones and all-zeros first, then random codes
    for (int i = 0; i < 12; i++) begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      t = 1'($urandom);
      @(posedge aclk);
      tx_act <= t;
      wr(A_CTRL, v, OK);
      rd(A_CTRL, v & 8'h7f);
      settle(2);
      check("ctrl_outs", {hv_en, conv_en, clk_oe, trig_oe, trim, trig_o},
            {v[6:0], v[3] & t});
    end
    wr(A_CTRL, 8'h00, OK, 4'h0);
    rd(A_CTRL, v & 8'h7f);
    $display("power control test done");
    for (int k = 0; k < 8; k++) begin
      v = {1'b1, 3'($urandom), 3'(k), 1'b1};
      wr(A_CFG, v, OK);
      rd(A_CFG, v & 8'h7e);
      settle(2);
      check("select", {ana_en, sel}, {k != 0, 3'(k)});
    end
    $display("monitor config test done");
    for (int k = 0; k < 3; k++) begin
      @(posedge aclk);
      stat <= 7'h7f & ~(7'h01 << sb[k]);
      wr(A_CFG, 8'h00, OK);
      settle(6);
      check("save_n", save_n, 1'b0);
      wr(A_CFG, 8'(1 << mb[k]), OK);
      settle(3);
      check("save_n", save_n, 1'b1);
    end
    @(posedge aclk);
    stat <= 7'h00;
    wr(A_CFG, 8'h70, OK);
    settle(6);
    check("save_n", save_n, 1'b1);
    wr(A_CFG, 8'h00, OK);
    @(posedge aclk);
    stat <= 7'h7f;
    settle(6);
    check("save_n", save_n, 1'b1);
    // clock enable low must freeze the monitor path
    @(posedge aclk);
    clk_en <= 1'b0;
    stat   <= 7'h00;
    settle(6);
    check("save_n", save_n, 1'b1);
    @(posedge aclk);
    clk_en <= 1'b1;
    settle(6);
    check("save_n", save_n, 1'b0);
    $display("save warning test done");
    for (int k = 0; k < 6; k++) begin
      s = 7'($urandom);
      @(posedge aclk);
      stat <= s;
      settle(6);
      rd(A_STAT, {1'b0, s});
      wr(A_STAT, 8'hff, OK);
      rd(A_STAT, {1'b0, s});
    end
    wr(6'h3c, 8'h55, ERR);
    rd(6'h3c, 8'h00, ERR);
    rd(6'h10, 8'h00, ERR);
    $display("status and unmapped test done");
    @(posedge aclk);
    stat <= 7'h7f;
    settle(6);
    wr(A_IMSK, 8'h00, OK);
    wr(A_IST, 8'h7f, OK);
    rd(A_IST, 8'h00);
    @(posedge aclk);
    stat <= 7'h3f;
    settle(6);
    check("irq", irq, 1'b0);
    rd(A_IST, 8'h40);
    wr(A_IMSK, 8'h40, OK);
    settle(3);
    check("irq", irq, 1'b1);
    wr(A_IST, 8'h40, OK);
    settle(3);
    check("irq", irq, 1'b0);
    rd(A_IST, 8'h00);
    $display("interrupt test done");
    settle(4);
    end_sim();
  end
endmodule // analog_supervision_regs_tb
